// ---- verilog/fpioc_defs.svh ----
// Function
// RL1: Customer word two accepts writes even while the memory is locked.
// RL2: Oscillator watchdog fault gives 5%, uncorrectable memory 10.625%, at half frequency.
// RL3: Self-test failure gives 16.25%, PLL unlock 21.875%, at half frequency.
// RL4: Zero-crossing fault gives 27.5%, averaging fault 33.125%, at half frequency.
// RL5: Undervoltage gives 38.75%, low field 44.375%, at half frequency.
// RL6: Soft memory error gives 50%, saturation 55.625%, at half frequency.
// RL7: High field gives 61.25%, temperature range 66.875%, at half frequency.
// RL8: Turns overflow gives 72.5% duty at half frequency.
// RL9: Turns alignment offset is added to the zero-cross angle for turns.
// RL10: Host recalibrates offset from angle difference, halved, plus old, modulo 2048.
// RL11: Quadrature cycles per turn equal two to the power fourteen minus code.
// RL12: In commutation mode the code is pole pairs minus one.
// RL13: Type bit picks commutation or quadrature; separate bit enables the pins.
// RL14: PLL unlock or watchdog forces all outputs high before inversion.
// RL15: Index mode sets index pulse width and placement around angle zero.
// RL16: Hysteresis bit selects the filtered angle for the incremental generator.
// RL17: Inversion bit inverts all incremental output signals.
// RL18: Slew field zero disables limiter, else edges at least (N+1)*125 ns apart.
// RL19: Each set mask bit keeps its error out of the aggregate flag.
// RL20: Aggregate flag is one while any unmasked error or warning is set.
// RL21: With error output on and duty coding, halve carrier, show top-priority error.
// RL22: Index unit R is one quadrature state step at the chosen resolution.
`ifndef FPIOC_DEFS_SVH
`define FPIOC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FPIOC_OFS_CUST2 8'h17
`define FPIOC_OFS_PWE 8'h18
`define FPIOC_OFS_INC 8'h19
`define FPIOC_OFS_MASK 8'h1a
`define FPIOC_OFS_PWMCTL 8'h1b
`define FPIOC_OFS_STATUS 8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPIOC_PWE_EN_MSB 12
`define FPIOC_PWE_OFS_LSB 13
`define FPIOC_INC_TYPE 4
`define FPIOC_INC_PINS_EN 5
`define FPIOC_INC_PLL_HIGH 6
`define FPIOC_INC_WDOG_HIGH 7
`define FPIOC_INC_IDX_LSB 8
`define FPIOC_INC_HYST 12
`define FPIOC_INC_INV 15
`define FPIOC_INC_SLEW_LSB 16
`define FPIOC_PWMCTL_SEL 12
`define FPIOC_PWMCTL_EN 13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FPIOC_RST_WORD 24'h000000

// ----------------------------------------
// Timing and duty coding
// ----------------------------------------
`define FPIOC_CLK_PERIOD_NS 100
`define FPIOC_SLEW_UNIT_NS 125
`define FPIOC_DUTY_BASE 80
`define FPIOC_DUTY_STEP 90
`define FPIOC_DUTY_SCALE 1600

`endif

// ---- verilog/fpioc_pkg.sv ----
`default_nettype none
package fpioc_pkg;
  // PWM output behaviour, Gray coded along normal -> fault -> off
  typedef enum logic [1:0]
  {
    FPIOC_PWM_NORMAL = 2'b00,
    FPIOC_PWM_FAULT = 2'b01,
    FPIOC_PWM_OFF = 2'b11
  } fpioc_pwm_mode_type;
endpackage
`default_nettype wire

// ---- verilog/fpioc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fpioc_defs.svh"

module fpioc_top
  import fpioc_pkg::*;
#(
  parameter int ANGLE_W = 16,
  parameter int PWM_PERIOD = 1000
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [23:0] rdata,
  input wire logic mem_locked,
  input wire logic [12:0] pwm_fault_in,
  input wire logic [23:0] err_status_in,
  input wire logic pll_unlock_in,
  input wire logic hf_watchdog_in,
  input wire logic [ANGLE_W-1:0] angle_raw,
  input wire logic [ANGLE_W-1:0] angle_hyst,
  input wire logic [11:0] angle_zero_cross,
  output logic [11:0] turns_angle,
  output logic aggregate_error_flag,
  output logic pwm_out,
  output logic pwm_oe,
  output logic [2:0] inc_out,
  output logic [2:0] inc_oe
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam int FAULT_PERIOD = 2 * PWM_PERIOD;
  localparam int CNT_W = $clog2(FAULT_PERIOD + 1);
  localparam int SLEW_CYC_W = 8;

  // High time of fault code k over the doubled carrier
  function automatic logic [CNT_W-1:0] fault_high(input int k);
    int prod;
    begin
      prod = FAULT_PERIOD * (`FPIOC_DUTY_BASE + `FPIOC_DUTY_STEP * k);
      fault_high = CNT_W'(prod / `FPIOC_DUTY_SCALE);
    end
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [23:0] customer_word_two;
  logic [23:0] pwm_fault_enables_and_turns_offset;
  logic [23:0] incremental_output_config;
  logic [23:0] error_flag_masks;
  logic pwm_error_output_en;
  logic pwm_error_response_select;

  // Software writes; locked memory refuses all but the customer word
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      customer_word_two <= `FPIOC_RST_WORD;
      pwm_fault_enables_and_turns_offset <= `FPIOC_RST_WORD;
      incremental_output_config <= `FPIOC_RST_WORD;
      error_flag_masks <= `FPIOC_RST_WORD;
      pwm_error_output_en <= 1'b0;
      pwm_error_response_select <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == `FPIOC_OFS_CUST2)
      begin
        customer_word_two <= wdata; // RL1
      end
      else if (mem_locked)
      begin
        // Locked: other words keep their value
      end
      else if (addr == `FPIOC_OFS_PWE)
      begin
        pwm_fault_enables_and_turns_offset <= wdata;
      end
      else if (addr == `FPIOC_OFS_INC)
      begin
        incremental_output_config <= wdata;
      end
      else if (addr == `FPIOC_OFS_MASK)
      begin
        error_flag_masks <= wdata;
      end
      else if (addr == `FPIOC_OFS_PWMCTL)
      begin
        pwm_error_response_select <= wdata[`FPIOC_PWMCTL_SEL];
        pwm_error_output_en <= wdata[`FPIOC_PWMCTL_EN];
      end
    end
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  logic [12:0] pwm_report_en;
  logic [10:0] turns_alignment_offset;
  logic [3:0] resolution_code;
  logic commutation_mode;
  logic incremental_pins_enable;
  logic pll_unlock_all_high_en;
  logic watchdog_all_high_en;
  logic [1:0] index_mode;
  logic quadrature_hysteresis_en;
  logic output_invert;
  logic [5:0] quadrature_slew_limit;

  assign pwm_report_en = pwm_fault_enables_and_turns_offset[`FPIOC_PWE_EN_MSB:0];
  assign turns_alignment_offset = pwm_fault_enables_and_turns_offset[23:`FPIOC_PWE_OFS_LSB];
  assign resolution_code = incremental_output_config[3:0];
  assign commutation_mode = incremental_output_config[`FPIOC_INC_TYPE];
  assign incremental_pins_enable = incremental_output_config[`FPIOC_INC_PINS_EN];
  assign pll_unlock_all_high_en = incremental_output_config[`FPIOC_INC_PLL_HIGH];
  assign watchdog_all_high_en = incremental_output_config[`FPIOC_INC_WDOG_HIGH];
  assign index_mode = incremental_output_config[`FPIOC_INC_IDX_LSB +: 2];
  assign quadrature_hysteresis_en = incremental_output_config[`FPIOC_INC_HYST];
  assign output_invert = incremental_output_config[`FPIOC_INC_INV];
  assign quadrature_slew_limit = incremental_output_config[`FPIOC_INC_SLEW_LSB +: 6];

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 24'h000000;
    end
    else if (rd)
    begin
      if (addr == `FPIOC_OFS_CUST2)
        rdata <= customer_word_two;
      else if (addr == `FPIOC_OFS_PWE)
        rdata <= pwm_fault_enables_and_turns_offset;
      else if (addr == `FPIOC_OFS_INC)
        rdata <= incremental_output_config;
      else if (addr == `FPIOC_OFS_MASK)
        rdata <= error_flag_masks;
      else if (addr == `FPIOC_OFS_PWMCTL)
        rdata <= {10'h000, pwm_error_output_en, pwm_error_response_select, 12'h000};
      else if (addr == `FPIOC_OFS_STATUS)
        rdata <= {10'h000, aggregate_error_flag, pwm_fault_in};
      else
        rdata <= 24'h000000;
    end
    else
    begin
      rdata <= 24'h000000;
    end
  end

  // ----------------------------------------
  // Aggregate error flag and turns angle
  // ----------------------------------------
  // Masked errors drop out of the flag
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      aggregate_error_flag <= 1'b0;
    else
      aggregate_error_flag <= |(err_status_in & ~error_flag_masks); // RL19 RL20
  end

  // Offset has half the angle resolution, so it is doubled first
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      turns_angle <= 12'h000;
    else
      turns_angle <= angle_zero_cross + {turns_alignment_offset, 1'b0}; // RL9
  end

  // ----------------------------------------
  // PWM fault selection
  // ----------------------------------------
  logic [12:0] active_faults;
  logic fault_any;
  logic [CNT_W-1:0] fault_high_sel;

  assign active_faults = pwm_fault_in & pwm_report_en;
  assign fault_any = |active_faults;

  // Lowest bit has the highest priority
  always_comb
  begin
    fault_high_sel = '0;
    for (int k = 12; k >= 0; k--)
    begin
      if (active_faults[k])
        fault_high_sel = fault_high(k); // RL2 RL3 RL4 RL5 RL6 RL7 RL8 RL21
    end
  end

  // ----------------------------------------
  // PWM generator
  // ----------------------------------------
  fpioc_pwm_mode_type pwm_mode;
  fpioc_pwm_mode_type next_pwm_mode;
  logic [CNT_W-1:0] pwm_cnt;
  logic [CNT_W-1:0] pwm_high;
  logic [CNT_W-1:0] pwm_last;
  logic [CNT_W-1:0] normal_high;
  logic [ANGLE_W+CNT_W-1:0] angle_prod;

  assign angle_prod = angle_raw * (ANGLE_W+CNT_W)'(PWM_PERIOD);
  assign normal_high = angle_prod[ANGLE_W +: CNT_W];

  // Mode picked by the error response bits
  always_comb
  begin
    next_pwm_mode = FPIOC_PWM_NORMAL;
    if (pwm_error_output_en && fault_any)
    begin
      if (pwm_error_response_select)
        next_pwm_mode = FPIOC_PWM_FAULT; // RL21
      else
        next_pwm_mode = FPIOC_PWM_OFF;
    end
  end

  // Mode and duty latch only at period end so no runt pulses appear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pwm_mode <= FPIOC_PWM_NORMAL;
      pwm_cnt <= '0;
      pwm_high <= '0;
      pwm_last <= CNT_W'(PWM_PERIOD - 1);
    end
    else if (pwm_cnt == pwm_last)
    begin
      pwm_cnt <= '0;
      pwm_mode <= next_pwm_mode;
      case (next_pwm_mode)
        FPIOC_PWM_FAULT:
        begin
          pwm_high <= fault_high_sel;
          pwm_last <= CNT_W'(FAULT_PERIOD - 1); // RL21
        end
        default:
        begin
          pwm_high <= normal_high;
          pwm_last <= CNT_W'(PWM_PERIOD - 1);
        end
      endcase
    end
    else
    begin
      pwm_cnt <= pwm_cnt + 1'b1;
    end
  end

  // Tristate response holds until error output is switched off or the faults clear at a period end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
    end
    else
    begin
      pwm_out <= (pwm_cnt < pwm_high);
      pwm_oe <= (pwm_mode != FPIOC_PWM_OFF) || !pwm_error_output_en;
    end
  end

  // ----------------------------------------
  // Incremental target
  // ----------------------------------------
  logic [ANGLE_W-1:0] inc_angle;
  logic [3:0] shift;
  logic [ANGLE_W-1:0] step_pos;
  logic [ANGLE_W-1:0] elec_angle;
  logic [ANGLE_W+2:0] sector_prod;
  logic [2:0] sector;
  logic idx_hit;
  logic [2:0] raw_target;
  logic [2:0] target;

  assign inc_angle = quadrature_hysteresis_en ? angle_hyst : angle_raw; // RL16
  // Code above 14 would exceed the angle grid; clamp it
  assign shift = (resolution_code > 4'he) ? 4'he : resolution_code;
  // Four states per cycle, so 2^(14-n) cycles per turn
  assign step_pos = inc_angle >> shift; // RL11 RL22
  assign elec_angle = ANGLE_W'(inc_angle * ({1'b0, resolution_code} + 5'h01)); // RL12
  assign sector_prod = elec_angle * (ANGLE_W+3)'(6);
  assign sector = sector_prod[ANGLE_W +: 3];

  // Index window placement around zero, in state steps
  always_comb
  begin
    case (index_mode)
      2'h0: idx_hit = (step_pos == '0);
      2'h1: idx_hit = (step_pos == '0) || (step_pos == {ANGLE_W{1'b1}} >> shift);
      2'h2: idx_hit = (step_pos <= ANGLE_W'(1)) || (step_pos == {ANGLE_W{1'b1}} >> shift);
      default: idx_hit = (step_pos <= ANGLE_W'(1)) ||
                         (step_pos >= (({ANGLE_W{1'b1}} >> shift) - ANGLE_W'(1)));
    endcase
  end

  // Quadrature or commutation pattern, then error and inversion
  always_comb
  begin
    if (commutation_mode) // RL13
    begin
      case (sector)
        3'h0: raw_target = 3'b100;
        3'h1: raw_target = 3'b110;
        3'h2: raw_target = 3'b010;
        3'h3: raw_target = 3'b011;
        3'h4: raw_target = 3'b001;
        default: raw_target = 3'b101;
      endcase
    end
    else
    begin
      case (step_pos[1:0])
        2'h0: raw_target = {2'b00, idx_hit}; // RL15
        2'h1: raw_target = {2'b10, idx_hit};
        2'h2: raw_target = {2'b11, idx_hit};
        default: raw_target = {2'b01, idx_hit};
      endcase
    end
    if ((pll_unlock_all_high_en && pll_unlock_in) ||
        (watchdog_all_high_en && hf_watchdog_in))
      raw_target = 3'b111; // RL14
    target = output_invert ? ~raw_target : raw_target; // RL17
  end

  // ----------------------------------------
  // Slew limiter and pins
  // ----------------------------------------
  logic [SLEW_CYC_W-1:0] slew_cycles;
  logic [SLEW_CYC_W-1:0] slew_timer;
  logic [15:0] slew_ns;

  // Least spacing rounds up to whole clock cycles
  assign slew_ns = 16'(({10'h000, quadrature_slew_limit} + 16'h0001) * `FPIOC_SLEW_UNIT_NS);
  assign slew_cycles = SLEW_CYC_W'((slew_ns + 16'(`FPIOC_CLK_PERIOD_NS - 1))
                                   / 16'(`FPIOC_CLK_PERIOD_NS));

  // Output follows target, but edges wait out the spacing timer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      inc_out <= 3'b000;
      slew_timer <= '0;
    end
    else if (slew_timer != '0)
    begin
      slew_timer <= slew_timer - 1'b1; // RL18
    end
    else if (target != inc_out)
    begin
      inc_out <= target;
      if (quadrature_slew_limit != 6'h00)
        slew_timer <= slew_cycles - 1'b1; // RL18
    end
  end

  // Pin drivers follow the pin enable bit
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      inc_oe <= 3'b000;
    else
      inc_oe <= {3{incremental_pins_enable}}; // RL13
  end

endmodule // fpioc_top
`default_nettype wire

// ---- verification/fpioc_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpioc_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [23:0] rdata,
  input wire logic [23:0] err_status_in,
  input wire logic aggregate_error_flag,
  input wire logic [11:0] angle_zero_cross,
  input wire logic [11:0] turns_angle,
  input wire logic [2:0] inc_oe
);
  // ----------------------------------------
  // Port relations in the mclk domain
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_rdata_idle;
    !rd |=> rdata == 24'h000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  property p_unmapped;
    rd && addr > 8'h40 |=> rdata == 24'h000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_flag_zero;
    err_status_in == 24'h000000 |=> !aggregate_error_flag;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flag set without status");
  property p_flag_rise;
    $rose(aggregate_error_flag) |-> $past(err_status_in) != 24'h000000;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without cause");
  // Mask and status both steady, so the flag may not move
  property p_flag_stable;
    !wr [*3] ##0 $stable(err_status_in) |=> $stable(aggregate_error_flag);
  endproperty
  a_flag_stable: assert property (p_flag_stable) else $error("flag moved on its own");
  property p_oe_same;
    inc_oe == 3'b000 || inc_oe == 3'b111;
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("pin enables differ");
  property p_oe_hold;
    !wr [*3] |-> $stable(inc_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved without write");
  // Offset is one cycle behind a write, the turns angle one more
  property p_turns_hold;
    !wr [*2] ##1 $stable(angle_zero_cross) |=> $stable(turns_angle);
  endproperty
  a_turns_hold: assert property (p_turns_hold) else $error("turns angle moved");
endmodule // fpioc_chk
bind fpioc_top fpioc_chk u_chk (
  .mclk(mclk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .err_status_in(err_status_in), .aggregate_error_flag(aggregate_error_flag),
  .angle_zero_cross(angle_zero_cross), .turns_angle(turns_angle), .inc_oe(inc_oe)
);
`default_nettype wire

// ---- verification/fpioc_pwm_meter.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpioc_pwm_meter (
  input wire logic mclk,
  input wire logic pwm_out,
  output logic [15:0] high_len,
  output logic [15:0] period_len
);
  // No initialisers: these are written by always_ff only, and an unknown
  // prev cannot fake a rising edge
  logic [15:0] run;
  logic [15:0] hi;
  logic prev;
  // ----------------------------------------
  // Controller side: times PWM from rise to rise
  // ----------------------------------------
  // Only rising edges latch, so a flat line keeps the last figures
  always_ff @(posedge mclk)
  begin
    prev <= pwm_out;
    run <= run + 16'h0001;
    if (pwm_out)
      hi <= hi + 16'h0001;
    if (pwm_out && !prev)
    begin
      period_len <= run;
      high_len <= hi;
      run <= 16'h0001;
      hi <= 16'h0001;
    end
  end
endmodule // fpioc_pwm_meter
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "fpioc_defs.svh"
module tb;
  localparam int P = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [23:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mem_locked = 1'b0;
  logic [12:0] fault = 13'h0000;
  logic [23:0] status = 24'h000000;
  logic pll = 1'b0;
  logic wdog = 1'b0;
  logic [15:0] angle = 16'h0000;
  logic [15:0] hyst = 16'h0000;
  logic [10:0] new_ofs;
  logic [11:0] zc = 12'h000;
  logic [23:0] rdata;
  logic [11:0] turns;
  logic flag;
  logic pwm;
  logic pwm_oe;
  logic [2:0] inc;
  logic [2:0] inc_oe;
  logic [15:0] high_len;
  logic [15:0] period_len;
  int mismatches = 0;
  int check_count = 0;
  fpioc_top #(.ANGLE_W(16), .PWM_PERIOD(P)) dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mem_locked(mem_locked), .pwm_fault_in(fault), .err_status_in(status),
    .pll_unlock_in(pll), .hf_watchdog_in(wdog), .angle_raw(angle), .angle_hyst(hyst),
    .angle_zero_cross(zc), .turns_angle(turns), .aggregate_error_flag(flag),
    .pwm_out(pwm), .pwm_oe(pwm_oe), .inc_out(inc), .inc_oe(inc_oe));
  fpioc_pwm_meter meter (.mclk(mclk), .pwm_out(pwm), .high_len(high_len),
    .period_len(period_len));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Strobe drops a full cycle before the next call may raise it
  task automatic wreg(input logic [7:0] a, input logic [23:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [23:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    cmp("rdata", exp, rdata);
    @(posedge mclk);
  endtask
  task automatic inc_case(input logic [23:0] cfg, input logic [15:0] a, input logic [2:0] exp);
    wreg(`FPIOC_OFS_INC, cfg);
    angle <= a;
    settle(3);
    cmp("inc_out", {21'h0, exp}, {21'h0, inc});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Free-running 10 MHz clock
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // Hang guard, several times the expected run
  initial
  begin
    settle(20000);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial
  begin
    settle(20);
    rst <= 1'b0;
    @(posedge mclk);
    for (int a = 8'h17; a <= 8'h1a; a++)
      rreg(8'(a), 24'h000000);
    rreg(8'h00, 24'h000000);
    rreg(8'h41, 24'h000000);
    mem_locked <= 1'b1;
    wreg(`FPIOC_OFS_CUST2, 24'h5a5a5a);
    wreg(`FPIOC_OFS_PWE, 24'h123456);
    rreg(`FPIOC_OFS_CUST2, 24'h5a5a5a);
    rreg(`FPIOC_OFS_PWE, 24'h000000);
    mem_locked <= 1'b0;
    for (int b = 0; b < 10; b++)
    begin
      status <= 24'(1) << b;
      wreg(`FPIOC_OFS_MASK, 24'(1) << b);
      settle(2);
      cmp("flag masked", 24'h0, {23'h0, flag});
      wreg(`FPIOC_OFS_MASK, ~(24'(1) << b));
      settle(2);
      cmp("flag unmasked", 24'h1, {23'h0, flag});
    end
    rreg(`FPIOC_OFS_STATUS, 24'h002000);
    status <= 24'h000000;
    zc <= 12'h800;
    wreg(`FPIOC_OFS_PWE, {11'h7ff, 13'h1fff});
    settle(3);
    cmp("turns", 24'h0007fe, {12'h0, turns});
    // Host realigns the offset so the turns angle meets a 12-bit angle of 0x9a4
    new_ofs = 11'((((12'h9a4 - turns) & 12'hfff) >> 1) + 12'h7ff);
    wreg(`FPIOC_OFS_PWE, {new_ofs, 13'h1fff});
    settle(3);
    cmp("turns", 24'h0009a4, {12'h0, turns});
    inc_case(24'h000022, 16'h0100, 3'b000);
    inc_case(24'h000022, 16'h0104, 3'b100);
    inc_case(24'h000022, 16'h0108, 3'b110);
    inc_case(24'h000022, 16'h010c, 3'b010);
    inc_case(24'h000022, 16'h0000, 3'b001);
    inc_case(24'h000022, 16'h0004, 3'b100);
    inc_case(24'h000322, 16'hfff8, 3'b111);
    inc_case(24'h000322, 16'h0008, 3'b110);
    inc_case(24'h001022, 16'h0104, 3'b001);
    hyst <= 16'h0108;
    inc_case(24'h001022, 16'h0104, 3'b110);
    inc_case(24'h008022, 16'h0104, 3'b011);
    pll <= 1'b1;
    inc_case(24'h000062, 16'h0104, 3'b111);
    inc_case(24'h008062, 16'h0104, 3'b000);
    pll <= 1'b0;
    wdog <= 1'b1;
    inc_case(24'h0000a2, 16'h0104, 3'b111);
    inc_case(24'h000022, 16'h0104, 3'b100);
    wdog <= 1'b0;
    inc_case(24'h000030, 16'h0000, 3'b100);
    inc_case(24'h000030, 16'h8000, 3'b011);
    inc_case(24'h000031, 16'h4000, 3'b011);
    cmp("inc_oe", 24'h7, {21'h0, inc_oe});
    wreg(`FPIOC_OFS_INC, 24'h000002);
    settle(3);
    cmp("inc_oe", 24'h0, {21'h0, inc_oe});
    // Slew code 3: (3+1)*125 ns rounds up to 5 cycles between edges
    inc_case(24'h030022, 16'h0100, 3'b000);
    angle <= 16'h0104;
    settle(1);
    cmp("inc_out", 24'h4, {21'h0, inc});
    angle <= 16'h0108;
    settle(2);
    cmp("inc_out", 24'h4, {21'h0, inc});
    settle(2);
    cmp("inc_out", 24'h4, {21'h0, inc});
    settle(1);
    cmp("inc_out", 24'h6, {21'h0, inc});
    wreg(`FPIOC_OFS_PWMCTL, 24'h003000);
    rreg(`FPIOC_OFS_PWMCTL, 24'h003000);
    for (int k = 0; k < 13; k++)
    begin
      fault <= 13'(1) << k;
      settle(10 * P);
      cmp("pwm period", 24'(2 * P), {8'h0, period_len});
      cmp("pwm high", 24'((2 * P * (80 + 90 * k)) / 1600), {8'h0, high_len});
    end
    fault <= 13'h1800;
    settle(10 * P);
    cmp("pwm high", 24'd26, {8'h0, high_len});
    wreg(`FPIOC_OFS_PWE, {11'h7ff, 13'h17ff});
    settle(10 * P);
    cmp("pwm high", 24'd29, {8'h0, high_len});
    cmp("pwm_oe", 24'h1, {23'h0, pwm_oe});
    wreg(`FPIOC_OFS_PWMCTL, 24'h002000);
    settle(6 * P);
    cmp("pwm_oe", 24'h0, {23'h0, pwm_oe});
    conclude();
  end
endmodule // tb
`default_nettype wire
